// file: rtl/slp_pkg.sv
/*
  Constants shared by the serial-to-parallel latch: widths, pin slots of the input
  synchroniser, reset values and the edge helper function.
  Assumes a single core clock; every pin is asynchronous to it.
*/
// Summary of operation
// [R1] eight-stage shift chain takes one serial bit per rising shift clock edge
// [R2] eight-bit storage register loads the chain and drives the parallel lines
// [R3] shift clock and storage clock are separate inputs, usable independently
// [R4] only rising edges of either clock act; falling edges change nothing
// [R5] with both clocks tied, storage takes the chain value from before the edge
// [R6] clear low zeroes every chain stage, overriding shift clock and serial input
// [R7] clear is active low; high lets shifting run normally
// [R8] last chain stage is driven on the cascade output for chaining devices
// [R9] parallel lines are three-state or open-collector, chosen by a parameter
// [R10] output enable is active low; high floats lines, stored data untouched
package slp_pkg;

  localparam int unsigned SLP_WIDTH      = 8;     // chain and storage width
  localparam int unsigned SLP_FIFO_DEPTH = 8;     // capture log depth
  localparam int unsigned SLP_NUM_PINS   = 5;     // synchronised input pins
  localparam int unsigned SLP_CNT_W      = 4;     // shift counter width

  // slots of the synchroniser vector
  localparam int unsigned SLP_PIN_SCK = 0;        // shift stage clock
  localparam int unsigned SLP_PIN_RCK = 1;        // storage capture clock
  localparam int unsigned SLP_PIN_CLR = 2;        // chain clear, active low
  localparam int unsigned SLP_PIN_SER = 3;        // serial data
  localparam int unsigned SLP_PIN_OEN = 4;        // output enable, active low

  // idle pin levels: clocks low, clear released, outputs disabled
  localparam logic [SLP_NUM_PINS-1:0] SLP_PIN_RST   = 5'h14;
  localparam logic [SLP_WIDTH-1:0]    SLP_CHAIN_RST = 8'h00;
  localparam logic [SLP_WIDTH-1:0]    SLP_STORE_RST = 8'h00;
  localparam logic [SLP_CNT_W-1:0]    SLP_CNT_RST   = 4'h0;
  localparam logic [SLP_CNT_W-1:0]    SLP_CNT_FULL  = 4'h8;

  // rising edge of a filtered level: the two late stages agree on high, old was low
  function automatic logic slp_rise(input logic agree, input logic lvl, input logic old);
    slp_rise = agree & lvl & ~old;
  endfunction : slp_rise

endpackage : slp_pkg

// file: rtl/slp_fifo_if.sv
/*
  Carrier between the latch and its capture log FIFO: write and read handshakes.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/100ps
interface slp_fifo_if #(
  parameter int unsigned WIDTH = 8
);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport fifo (
    input  wr_valid,
    output wr_ready,
    input  wr_data,
    output rd_valid,
    input  rd_ready,
    output rd_data
  );

  modport user (
    output wr_valid,
    input  wr_ready,
    output wr_data,
    input  rd_valid,
    output rd_ready,
    input  rd_data
  );
endinterface : slp_fifo_if

// file: rtl/slp_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides, used as the capture log.
  Assumes one clock, asynchronous active-low reset and a freezing clock enable.
*/
`timescale 1ns/100ps
module slp_fifo
  import slp_pkg::*;
#(
  parameter int unsigned WIDTH = SLP_WIDTH,
  parameter int unsigned DEPTH = SLP_FIFO_DEPTH
) (
  input  logic   core_clk,
  input  logic   rstn,
  input  logic   ce,
  slp_fifo_if.fifo port_f
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      count_r;
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  wire              do_wr;
  wire              do_rd;
  wire  [AW-1:0]    wr_ptr_nxt;
  wire  [AW-1:0]    rd_ptr_nxt;

  // full and empty come straight from the occupancy count
  assign port_f.wr_ready = (count_r != (AW+1)'(DEPTH));
  assign port_f.rd_valid = (count_r != '0);
  assign port_f.rd_data  = mem[rd_ptr_r];
  assign do_wr           = ce & port_f.wr_valid & port_f.wr_ready;
  assign do_rd           = ce & port_f.rd_valid & port_f.rd_ready;
  assign wr_ptr_nxt      = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
  assign rd_ptr_nxt      = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);

  // storage array has no reset; only written words are ever read
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= port_f.wr_data;
    end
  end

  // pointers and count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_wr) wr_ptr_r <= wr_ptr_nxt;
      if (do_rd) rd_ptr_r <= rd_ptr_nxt;
      if (do_wr && !do_rd) count_r <= count_r + (AW+1)'(1);
      else if (do_rd && !do_wr) count_r <= count_r - (AW+1)'(1);
    end
  end
endmodule : slp_fifo

// file: rtl/slp_latch.sv
/*
  Serial-in parallel-out shift chain with a storage register, cascade output and
  three-state or open-collector parallel drivers, plus a log of captured words.
  Assumes all pins are asynchronous to core_clk and that each pin level holds for
  at least three core clock cycles; pulses of a single core clock cycle are filtered away.
*/
`timescale 1ns/100ps
module slp_latch
  import slp_pkg::*;
#(
  parameter int unsigned WIDTH          = SLP_WIDTH,
  parameter int unsigned FIFO_DEPTH     = SLP_FIFO_DEPTH,
  parameter bit          OPEN_COLLECTOR = 1'b0
) (
  input  logic             core_clk,
  input  logic             rstn,
  input  logic             ce,
  input  logic             shift_stage_clock,
  input  logic             storage_capture_clock,
  input  logic             chain_clear_n,
  input  logic             serial_bit_in,
  input  logic             out_enable_n,
  output logic [WIDTH-1:0] parallel_lines_out,
  output logic [WIDTH-1:0] parallel_lines_oe,
  output logic             cascade_bit_out,
  output logic [WIDTH-1:0] storage_word,
  output logic [SLP_CNT_W-1:0] shifts_pending,
  output logic             chain_full,
  output logic             cap_valid,
  input  logic             cap_ready,
  output logic [WIDTH-1:0] cap_data,
  output logic             cap_room,
  output logic             cap_dropped,
  input  logic             cap_dropped_clr
);

  // synchroniser: three stages per pin, first stage feeds only the second
  logic [SLP_NUM_PINS-1:0] sync1_r;
  logic [SLP_NUM_PINS-1:0] sync2_r;
  logic [SLP_NUM_PINS-1:0] sync3_r;
  logic [SLP_NUM_PINS-1:0] lvl_r;
  wire  [SLP_NUM_PINS-1:0] pins_raw;
  wire  [SLP_NUM_PINS-1:0] agree;
  wire  [SLP_NUM_PINS-1:0] lvl_nxt;

  logic [WIDTH-1:0]     chain_r;
  logic [WIDTH-1:0]     storage_r;
  logic [SLP_CNT_W-1:0] cnt_r;
  logic                 dropped_r;
  logic [WIDTH-1:0]     pad_out_r;
  logic [WIDTH-1:0]     pad_oe_r;

  wire                  sck_rise;
  wire                  rck_rise;
  wire                  clr_active;
  wire                  ser_lvl;
  wire                  out_en;
  wire  [WIDTH-1:0]     chain_nxt;
  wire  [WIDTH-1:0]     storage_nxt;
  wire  [SLP_CNT_W-1:0] cnt_nxt;
  wire  [WIDTH-1:0]     pad_out_nxt;
  wire  [WIDTH-1:0]     pad_oe_nxt;
  wire                  push_drop;

  slp_fifo_if #(.WIDTH(WIDTH)) log_if ();

  // pin gathering and the agree-based filter
  assign pins_raw[SLP_PIN_SCK] = shift_stage_clock;
  assign pins_raw[SLP_PIN_RCK] = storage_capture_clock;
  assign pins_raw[SLP_PIN_CLR] = chain_clear_n;
  assign pins_raw[SLP_PIN_SER] = serial_bit_in;
  assign pins_raw[SLP_PIN_OEN] = out_enable_n;
  assign agree   = ~(sync2_r ^ sync3_r);
  assign lvl_nxt = (agree & sync3_r) | (~agree & lvl_r);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= SLP_PIN_RST;
      sync2_r <= SLP_PIN_RST;
      sync3_r <= SLP_PIN_RST;
      lvl_r   <= SLP_PIN_RST;
    end else if (ce) begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      lvl_r   <= lvl_nxt;
    end
  end

  // separate edge detectors, so the two clocks never depend on each other
  assign sck_rise   = slp_rise(agree[SLP_PIN_SCK], sync3_r[SLP_PIN_SCK],
                               lvl_r[SLP_PIN_SCK]);  // [R3] [R4]
  assign rck_rise   = slp_rise(agree[SLP_PIN_RCK], sync3_r[SLP_PIN_RCK],
                               lvl_r[SLP_PIN_RCK]);  // [R3] [R4]
  assign clr_active = ~lvl_r[SLP_PIN_CLR];           // [R7]
  assign ser_lvl    = lvl_nxt[SLP_PIN_SER];          // data as seen at the clock edge
  assign out_en     = ~lvl_r[SLP_PIN_OEN];           // [R10]

  // chain: clear beats shifting for every cycle it is held low
  assign chain_nxt = clr_active ? SLP_CHAIN_RST :                      // [R6]
                     sck_rise   ? {chain_r[WIDTH-2:0], ser_lvl} :      // [R1]
                                  chain_r;

  // storage reads the chain as it stood before this edge, so a tied clock lags one
  assign storage_nxt = rck_rise ? chain_r : storage_r;                  // [R2] [R5]

  // count of shifts since the last capture or clear, saturating at a full word
  assign cnt_nxt = (clr_active || rck_rise) ? SLP_CNT_RST :
                   (sck_rise && cnt_r != SLP_CNT_FULL) ? cnt_r + SLP_CNT_W'(1) :
                                                         cnt_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      chain_r   <= SLP_CHAIN_RST;
      storage_r <= SLP_STORE_RST;
      cnt_r     <= SLP_CNT_RST;
    end else if (ce) begin
      chain_r   <= chain_nxt;
      storage_r <= storage_nxt;
      cnt_r     <= cnt_nxt;
    end
  end

  // pad drivers: three-state drives the value, open-collector only pulls low
  assign pad_out_nxt = OPEN_COLLECTOR ? '0 : storage_r;                 // [R9]
  assign pad_oe_nxt  = !out_en        ? '0 :                            // [R10]
                       OPEN_COLLECTOR ? ~storage_r : {WIDTH{1'b1}};     // [R9]

  // registered pads cost one cycle but keep the pin drive glitch free
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pad_out_r <= '0;
      pad_oe_r  <= '0;
    end else if (ce) begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r  <= pad_oe_nxt;
    end
  end

  // capture log: every storage edge pushes the captured word while the log has room
  assign log_if.wr_valid = rck_rise;
  assign log_if.wr_data  = chain_r;
  assign log_if.rd_ready = cap_ready;
  assign push_drop       = rck_rise & ~log_if.wr_ready;

  // a word lost to a full log is flagged; a new loss wins over a clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dropped_r <= 1'b0;
    end else if (ce) begin
      dropped_r <= push_drop | (dropped_r & ~cap_dropped_clr);
    end
  end

  slp_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_log (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .port_f   (log_if)
  );

  // outputs
  assign parallel_lines_out = pad_out_r;
  assign parallel_lines_oe  = pad_oe_r;
  assign cascade_bit_out    = chain_r[WIDTH-1];  // [R8]
  assign storage_word       = storage_r;
  assign shifts_pending     = cnt_r;
  assign chain_full         = (cnt_r == SLP_CNT_FULL);
  assign cap_valid          = log_if.rd_valid;
  assign cap_data           = log_if.rd_data;
  assign cap_room           = log_if.wr_ready;
  assign cap_dropped        = dropped_r;

endmodule : slp_latch

// file: tb/slp_latch_checker.sv
/* Port checker for slp_latch, bound to every instance.
   Assumes pin levels hold at least four core clocks. */
`timescale 1ns/100ps
module slp_latch_checker
  import slp_pkg::*;
#(
  parameter int unsigned WIDTH          = SLP_WIDTH,
  parameter bit          OPEN_COLLECTOR = 1'b0
) (
  input logic                 core_clk,
  input logic                 rstn,
  input logic                 shift_stage_clock,
  input logic                 storage_capture_clock,
  input logic                 chain_clear_n,
  input logic                 out_enable_n,
  input logic [WIDTH-1:0]     parallel_lines_out,
  input logic [WIDTH-1:0]     parallel_lines_oe,
  input logic                 cascade_bit_out,
  input logic [WIDTH-1:0]     storage_word,
  input logic [SLP_CNT_W-1:0] shifts_pending,
  input logic                 chain_full,
  input logic                 cap_room,
  input logic                 cap_dropped,
  input logic                 cap_dropped_clr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // six quiet cycles outlast the three-stage pin filter, so levels must have acted
  full_flag_a: assert property (chain_full == (shifts_pending == SLP_CNT_FULL))
    else $error("chain full flag wrong");
  // open-collector enables follow the data bits, so only three-state drives as a group
  pad_group_a: assert property (OPEN_COLLECTOR || parallel_lines_oe == '0
    || parallel_lines_oe == '1) else $error("pad enables split");
  pad_data_a: assert property (parallel_lines_oe != '0
    |-> parallel_lines_out == (OPEN_COLLECTOR ? '0 : $past(storage_word)))
    else $error("pads differ from storage");
  oc_pull_a: assert property ((OPEN_COLLECTOR && !out_enable_n) [*6]
    |-> parallel_lines_oe == ~$past(storage_word)) else $error("open-collector pull wrong");
  oe_float_a: assert property (out_enable_n [*6] |-> parallel_lines_oe == '0)
    else $error("pads driven while disabled");
  store_hold_a: assert property (!storage_capture_clock [*6] |-> $stable(storage_word))
    else $error("storage moved without capture edge");
  chain_hold_a: assert property ((!shift_stage_clock && chain_clear_n) [*6]
    |-> $stable(cascade_bit_out)) else $error("cascade moved without shift edge");
  clear_zero_a: assert property (!chain_clear_n [*6]
    |-> !cascade_bit_out && shifts_pending == SLP_CNT_RST) else $error("clear ignored");
  drop_cause_a: assert property ($rose(cap_dropped) |-> !$past(cap_room))
    else $error("drop flagged with room");
  drop_clear_a: assert property ($past(cap_dropped_clr) && $past(cap_room)
    && $past(cap_room, 2) |-> !cap_dropped) else $error("drop flag not cleared");
endmodule : slp_latch_checker

bind slp_latch slp_latch_checker #(.WIDTH(WIDTH), .OPEN_COLLECTOR(OPEN_COLLECTOR)) chk (
  .core_clk, .rstn, .shift_stage_clock, .storage_capture_clock, .chain_clear_n,
  .out_enable_n, .parallel_lines_out, .parallel_lines_oe, .cascade_bit_out,
  .storage_word, .shifts_pending, .chain_full, .cap_room, .cap_dropped, .cap_dropped_clr
);

// file: tb/slp_host.sv
/* Host controller model driving the five latch pins.
   Assumes its tasks are called just after a core clock edge. */
`timescale 1ns/100ps
module slp_host (
  input  logic core_clk,
  output logic shift_stage_clock,
  output logic storage_capture_clock,
  output logic chain_clear_n,
  output logic serial_bit_in,
  output logic out_enable_n
);
  // idle: clocks low, clear released, pads floated
  initial begin
    shift_stage_clock     = 1'b0;
    storage_capture_clock = 1'b0;
    chain_clear_n         = 1'b1;
    serial_bit_in         = 1'b0;
    out_enable_n          = 1'b1;
  end

  // four cycles per level, one more than the filter needs
  task automatic hold();
    repeat (4) @(posedge core_clk);
  endtask : hold

  // data set up and held around the rise; cap ties the storage clock to it
  task automatic tick(input logic b, input logic cap);
    serial_bit_in <= b;
    hold();
    shift_stage_clock     <= 1'b1;
    storage_capture_clock <= cap;
    hold();
    shift_stage_clock     <= 1'b0;
    storage_capture_clock <= 1'b0;
    hold();
    #1;
  endtask : tick

  // storage clock alone, shift clock left still
  task automatic strobe();
    storage_capture_clock <= 1'b1;
    hold();
    storage_capture_clock <= 1'b0;
    hold();
    #1;
  endtask : strobe

  // static levels; two holds let the registered pads follow too
  task automatic level(input logic clr_v, input logic oe_v);
    chain_clear_n <= clr_v;
    out_enable_n  <= oe_v;
    hold();
    hold();
    #1;
  endtask : level
endmodule : slp_host

// file: tb/slp_latch_test.sv
/* Self-checking bench for slp_latch, pins driven by the host model.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/100ps
module slp_latch_test;
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       ce = 1'b1;
  logic       cap_ready = 1'b0;
  logic       cap_dropped_clr = 1'b0;
  logic       shift_stage_clock, storage_capture_clock, chain_clear_n, serial_bit_in;
  logic       out_enable_n, cascade_bit_out, chain_full, cap_valid, cap_room, cap_dropped;
  logic [7:0] parallel_lines_out, parallel_lines_oe, storage_word, cap_data;
  logic [7:0] oc_lines_out, oc_lines_oe;
  logic [3:0] shifts_pending;
  int         err_total = 0;
  int         total_checks = 0;

  always #5 core_clk = ~core_clk;

  slp_host host (.core_clk, .shift_stage_clock, .storage_capture_clock, .chain_clear_n,
    .serial_bit_in, .out_enable_n);
  slp_latch dut (.core_clk, .rstn, .ce, .shift_stage_clock, .storage_capture_clock,
    .chain_clear_n, .serial_bit_in, .out_enable_n, .parallel_lines_out, .parallel_lines_oe,
    .cascade_bit_out, .storage_word, .shifts_pending, .chain_full, .cap_valid, .cap_ready,
    .cap_data, .cap_room, .cap_dropped, .cap_dropped_clr);
  // open-collector twin on the same pins, so both pad variants are judged
  slp_latch #(.OPEN_COLLECTOR(1'b1)) dut_oc (.core_clk, .rstn, .ce, .shift_stage_clock,
    .storage_capture_clock, .chain_clear_n, .serial_bit_in, .out_enable_n,
    .parallel_lines_out(oc_lines_out), .parallel_lines_oe(oc_lines_oe), .cascade_bit_out(),
    .storage_word(), .shifts_pending(), .chain_full(), .cap_valid(), .cap_ready,
    .cap_data(), .cap_room(), .cap_dropped(), .cap_dropped_clr);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one log word out; the log stalls whenever this is not called
  task automatic pop();
    cap_ready <= 1'b1;
    @(posedge core_clk);
    cap_ready <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask : pop

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic t_shift();
    logic [7:0] v = 8'ha5;
    chk(parallel_lines_oe, 8'h00);
    for (int i = 7; i >= 0; i--) begin
      host.tick(v[i], 1'b0);
    end
    chk(storage_word, 8'h00);
    chk({7'h0, cascade_bit_out}, 8'h01);
    chk({7'h0, chain_full}, 8'h01);
    host.strobe();
    chk(storage_word, v);
    chk(cap_data, v);
    pop();
    host.level(1'b1, 1'b0);
    chk(parallel_lines_oe, 8'hff);
    chk(parallel_lines_out, v);
    chk(oc_lines_oe, 8'h5a);
    chk(oc_lines_out, 8'h00);
    host.level(1'b1, 1'b1);
    chk(parallel_lines_oe | oc_lines_oe, 8'h00);
    chk(storage_word, v);
    $display("shift test done");
  endtask : t_shift

  task automatic t_clear();
    host.tick(1'b1, 1'b0);
    host.level(1'b0, 1'b1);
    host.tick(1'b1, 1'b0);
    chk({4'h0, shifts_pending}, 8'h00);
    host.strobe();
    chk(storage_word, 8'h00);
    pop();
    host.level(1'b1, 1'b1);
    host.tick(1'b1, 1'b0);
    chk({4'h0, shifts_pending}, 8'h01);
    $display("clear test done");
  endtask : t_clear

  // chain starts at 01, so storage trails by one edge: 9e, then 3c
  task automatic t_tied();
    logic [7:0] v = 8'h3c;
    for (int i = 7; i >= 0; i--) begin
      host.tick(v[i], 1'b1);
      pop();
    end
    chk(storage_word, 8'h9e);
    host.tick(1'b0, 1'b1);
    pop();
    chk(storage_word, v);
    $display("tied clock test done");
  endtask : t_tied

  // chain holds 78; nine captures overflow the eight-word log
  task automatic t_fifo();
    for (int i = 0; i < 9; i++) begin
      host.strobe();
    end
    chk({6'h0, cap_room, cap_dropped}, 8'h01);
    pop();
    cap_dropped_clr <= 1'b1;
    @(posedge core_clk);
    cap_dropped_clr <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({7'h0, cap_dropped}, 8'h00);
    for (int i = 0; i < 7; i++) begin
      chk(cap_data, 8'h78);
      pop();
    end
    chk({7'h0, cap_valid}, 8'h00);
    $display("log test done");
  endtask : t_fifo

  // enable low freezes the filter too, so a whole tied pulse must go unseen
  task automatic t_hold();
    ce <= 1'b0;
    host.tick(1'b1, 1'b1);
    ce <= 1'b1;
    chk({7'h0, cap_valid}, 8'h00);
    chk({7'h0, cascade_bit_out}, 8'h00);
    chk(storage_word, 8'h78);
    $display("freeze test done");
  endtask : t_hold

  // reset in mid-run empties storage and log; the first shift after release counts
  task automatic t_reset();
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(storage_word, 8'h00);
    chk({6'h0, cap_room, cap_valid}, 8'h02);
    host.tick(1'b1, 1'b0);
    chk({4'h0, shifts_pending}, 8'h01);
    chk({7'h0, cascade_bit_out}, 8'h00);
    $display("reset test done");
  endtask : t_reset

  // hang guard, far beyond the roughly 440 cycles a clean run needs
  initial begin
    #300000;
    err_total++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    t_shift();
    t_clear();
    t_tied();
    t_fifo();
    t_hold();
    t_reset();
    close_out();
  end
endmodule : slp_latch_test
